//--- shared/led_sink_pkg.sv
// constants for the single-wire edge-counting led sink controller
// assumes a 40 MHz system clock and a 1 MHz internal timing tick
package led_sink_pkg;
	localparam int unsigned CLK_HZ           = 40_000_000;
	localparam int unsigned OSC_HZ           = 1_000_000;
	localparam int unsigned OSC_DIV          = CLK_HZ / OSC_HZ;
	localparam int unsigned LATCH_TIMEOUT_US = 500;
	localparam int unsigned OFF_TIMEOUT_US   = 500;
	localparam int unsigned SOFT_START_US    = 200;
	localparam int unsigned LATCH_TICKS      = LATCH_TIMEOUT_US;
	localparam int unsigned OFF_TICKS        = OFF_TIMEOUT_US;
	localparam int unsigned SOFT_TICKS       = SOFT_START_US;
	localparam int unsigned TICK_W           = 12;

	localparam logic [4:0] ADDR_EDGE_BASE = 5'h11;
	localparam logic [4:0] DATA_EDGE_MAX  = 5'h10;
	localparam logic [4:0] EDGE_MAX       = 5'h17;

	localparam logic [2:0] ADDR_BOTH  = 3'h0;
	localparam logic [2:0] ADDR_FIRST = 3'h1;
	localparam logic [2:0] ADDR_SECND = 3'h2;
	localparam logic [2:0] ADDR_SCALE = 3'h3;
	localparam logic [2:0] ADDR_ONOFF = 3'h4;
	localparam logic [2:0] ADDR_RSVD  = 3'h5;
	localparam logic [2:0] ADDR_MODE  = 3'h6;

	localparam logic [3:0] SCALE_LO_LO = 4'h1;
	localparam logic [3:0] SCALE_HI_HI = 4'h2;
	localparam logic [3:0] SCALE_LO_HI = 4'h3;
	localparam logic [3:0] SCALE_SCALE_SELECT = 4'h4;
	localparam logic [3:0] ONOFF_ON    = 4'h1;
	localparam logic [3:0] ONOFF_OFF   = 4'h2;
	localparam logic [3:0] MODE_CURR   = 4'h1;
	localparam logic [3:0] MODE_VOLT   = 4'h2;

	// data code 16 is stored as 0 in four bits and means zero current
	localparam logic [3:0] LEVEL_ZERO   = 4'h0;
	localparam logic [3:0] LEVEL_RESET  = 4'h0;
	localparam logic       SCALE_RESET  = 1'b0;
	localparam logic [3:0] ONOFF_RESET  = 4'h1;

	localparam logic [1:0] RATIO_1X  = 2'h0;
	localparam logic [1:0] RATIO_15X = 2'h1;
	localparam logic [1:0] RATIO_2X  = 2'h2;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_SOFT  = 2'b01,
		ST_RUN   = 2'b10
	} pump_state_e;
endpackage

//--- logic/osc_tick.sv
// 1 MHz timing tick derived from the system clock
// assumes DIV is at least two
`timescale 1ns/100ps
module osc_tick
	import led_sink_pkg::*;
#(
	parameter int unsigned DIV = OSC_DIV
) (
	input  wire logic ref_clk_in, // system clock
	input  wire logic rst_in,     // async reset, high
	output logic      tick_out    // one-cycle pulse at 1 MHz
);
	logic [7:0] cnt_q;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= 8'h00;
			tick_out <= 1'b0;
		end else if (cnt_q == 8'(DIV - 1)) begin
			cnt_q    <= 8'h00;
			tick_out <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 8'h01;
			tick_out <= 1'b0;
		end
	end
endmodule

//--- logic/tick_timer.sv
// counts ticks while a condition holds and flags when a limit is hit
// assumes run_in is a synchronous level
`timescale 1ns/100ps
module tick_timer
	import led_sink_pkg::*;
#(
	parameter int unsigned LIMIT = 500
) (
	input  wire logic ref_clk_in, // system clock
	input  wire logic rst_in,     // async reset, high
	input  wire logic run_in,     // count while high, clear while low
	input  wire logic tick_in,    // 1 MHz tick
	output logic      done_out    // level, high once limit reached
);
	logic [TICK_W-1:0] cnt_q;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= '0;
			done_out <= 1'b0;
		end else if (!run_in) begin
			cnt_q    <= '0;
			done_out <= 1'b0;
		end else if (tick_in && !done_out) begin
			cnt_q    <= cnt_q + 1'b1;
			done_out <= (cnt_q == TICK_W'(LIMIT - 1));
		end
	end
endmodule

//--- logic/led_sink_ctrl.sv
// edge-counting single-wire control for a dual led sink charge pump
// assumes the control pin is asynchronous; analog pump stages outside
`timescale 1ns/100ps
module led_sink_ctrl
	import led_sink_pkg::*;
#(
	parameter int unsigned LATCH_CYC = LATCH_TICKS,
	parameter int unsigned OFF_CYC   = OFF_TICKS,
	parameter int unsigned SOFT_CYC  = SOFT_TICKS
) (
	input  wire logic       ref_clk_in,       // 40 MHz system clock
	input  wire logic       rst_in,           // async reset, high
	input  wire logic       ctrl_pin_in,      // single-wire control pin
	input  wire logic       pump_low_in,      // output cannot sustain sink
	input  wire logic       pump_high_in,     // headroom allows lower ratio
	output logic [3:0]      first_level_out,  // first_current_sink code
	output logic [3:0]      second_level_out, // second_current_sink code
	output logic            first_high_out,   // first sink on high scale
	output logic            second_high_out,  // second sink on high scale
	output logic            sinks_on_out,     // sinks enabled
	output logic            standby_out,      // low-current standby
	output logic            voltage_mode_out, // regulated 4.5 V mode
	output logic            pump_en_out,      // charge pump running
	output logic            soft_start_out,   // inrush limit active
	output logic [1:0]      pump_ratio_out,   // 0 1x, 1 1.5x, 2 2x
	output logic            shutdown_out,     // device in shutdown
	output logic [2:0]      addr_out          // selected address
);
	// ****************************************************************
	// pin synchroniser and edge detect
	// ****************************************************************
	logic pin_s1_q, pin_s2_q, pin_d_q;
	logic rise;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_d_q  <= 1'b0;
		end else begin
			pin_s1_q <= ctrl_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_d_q  <= pin_s2_q;
		end
	end

	assign rise = pin_s2_q && !pin_d_q;
	// ****************************************************************
	// timing: oscillator tick and timeouts
	// ****************************************************************
	logic tick, latch_done, off_done, soft_done;
	logic in_soft;

	osc_tick #(.DIV(OSC_DIV)) u_osc (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.tick_out   (tick)
	);
	// pin high after a burst: latch timer
	tick_timer #(.LIMIT(LATCH_CYC)) u_latch (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.run_in     (pin_s2_q),
		.tick_in    (tick),
		.done_out   (latch_done)
	);

	// pin low: shutdown timer
	tick_timer #(.LIMIT(OFF_CYC)) u_off (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.run_in     (!pin_s2_q),
		.tick_in    (tick),
		.done_out   (off_done)
	);

	tick_timer #(.LIMIT(SOFT_CYC)) u_soft (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.run_in     (in_soft),
		.tick_in    (tick),
		.done_out   (soft_done)
	);

	// ****************************************************************
	// shutdown state
	// ****************************************************************
	logic shut_q;
	// off flag lags the pin a cycle; gate it so the waking edge counts
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			shut_q <= 1'b1;
		end else if (off_done && !pin_s2_q) begin
			shut_q <= 1'b1;
		end else if (rise) begin
			shut_q <= 1'b0;
		end
	end

	// ****************************************************************
	// burst counting
	// ****************************************************************
	logic [4:0] edge_q;
	logic       burst_q;
	logic       latch_now;

	// saturate so a runaway burst does not wrap into a data code
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			edge_q  <= 5'h00;
			burst_q <= 1'b0;
		end else if ((off_done && !pin_s2_q) || latch_now) begin
			edge_q  <= 5'h00;
			burst_q <= 1'b0;
		end else if (rise) begin
			burst_q <= 1'b1;
			if (edge_q != EDGE_MAX + 5'h01) begin
				edge_q <= edge_q + 5'h01;
			end
		end
	end

	assign latch_now = latch_done && burst_q;

	// ****************************************************************
	// decode and register file
	// ****************************************************************
	logic [2:0] addr_q;
	logic [3:0] lvl1_q, lvl2_q, onoff_q, mode_q;
	logic       hi1_q, hi2_q, volt_q;
	logic       is_data, is_addr;
	logic [3:0] dval;

	assign is_data = latch_now && edge_q <= DATA_EDGE_MAX;
	assign is_addr = latch_now && edge_q >= ADDR_EDGE_BASE
		&& edge_q <= EDGE_MAX;
	assign dval    = edge_q[3:0]; // 16 folds to 0, the zero-current code

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_q <= ADDR_BOTH;
		end else if (shut_q) begin
			addr_q <= ADDR_BOTH;
		end else if (is_addr) begin
			addr_q <= 3'(edge_q - ADDR_EDGE_BASE);
		end
	end // held across data writes

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lvl1_q <= LEVEL_RESET;
			lvl2_q <= LEVEL_RESET;
		end else if (shut_q) begin
			lvl1_q <= LEVEL_RESET;
			lvl2_q <= LEVEL_RESET;
		end else if (is_data) begin
			if (addr_q == ADDR_BOTH) begin
				lvl1_q <= dval;
				lvl2_q <= dval;
			end else if (addr_q == ADDR_FIRST) begin
				lvl1_q <= dval;
			end else if (addr_q == ADDR_SECND) begin
				lvl2_q <= dval;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hi1_q <= SCALE_RESET;
			hi2_q <= SCALE_RESET;
		end else if (shut_q) begin
			hi1_q <= SCALE_RESET;
			hi2_q <= SCALE_RESET;
		end else if (is_data && addr_q == ADDR_SCALE) begin
			if (dval == SCALE_LO_LO) begin
				hi1_q <= 1'b0;
				hi2_q <= 1'b0;
			end else if (dval == SCALE_HI_HI) begin
				hi1_q <= 1'b1;
				hi2_q <= 1'b1;
			end else if (dval == SCALE_LO_HI) begin
				hi1_q <= 1'b0;
				hi2_q <= 1'b1;
			end else if (dval == SCALE_SCALE_SELECT) begin
				hi1_q <= 1'b1;
				hi2_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			onoff_q <= ONOFF_RESET;
		end else if (shut_q) begin
			onoff_q <= ONOFF_RESET;
		end else if (is_data && addr_q == ADDR_ONOFF
			&& (dval == ONOFF_ON || dval == ONOFF_OFF)) begin
			onoff_q <= dval;
		end
	end

	// register 6 holds the mode request; 5 with 1 also forces current
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= MODE_CURR;
		end else if (shut_q) begin
			mode_q <= MODE_CURR;
		end else if (is_data && addr_q == ADDR_MODE
			&& (dval == MODE_CURR || dval == MODE_VOLT)) begin
			mode_q <= dval;
		end else if (is_data && addr_q == ADDR_RSVD
			&& dval == MODE_CURR) begin
			mode_q <= MODE_CURR;
		end
	end

	// ****************************************************************
	// mode resolution and pump sequencing
	// ****************************************************************
	logic        sink_active;
	pump_state_e st_q;
	logic [1:0]  ratio_q;

	assign sink_active = onoff_q == ONOFF_ON
		&& (lvl1_q != LEVEL_ZERO || lvl2_q != LEVEL_ZERO);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			volt_q <= 1'b0;
		end else begin
			// recomputed each cycle so voltage mode resumes at zero current
			volt_q <= !shut_q && mode_q == MODE_VOLT
				&& !sink_active;
		end
	end

	assign in_soft = st_q == ST_SOFT;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q        <= ST_OFF;
		end else begin
			case (st_q)
			ST_OFF: begin
				if (!shut_q) begin
					st_q <= ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (shut_q) begin
					st_q <= ST_OFF;
				end else if (soft_done) begin
					st_q <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (shut_q) begin
					st_q <= ST_OFF;
				end
			end
			default: begin
				st_q <= ST_OFF;
			end
			endcase
		end
	end

	// ratio steps on oscillator ticks; voltage mode pins it at 1.5x
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ratio_q <= RATIO_1X;
		end else if (st_q == ST_OFF) begin
			ratio_q <= RATIO_1X;
		end else if (volt_q) begin
			ratio_q <= RATIO_15X;
		end else if (tick) begin
			if (pump_low_in && ratio_q != RATIO_2X) begin
				ratio_q <= ratio_q + 2'h1;
			end else if (pump_high_in && !pump_low_in
				&& ratio_q != RATIO_1X) begin
				ratio_q <= ratio_q - 2'h1;
			end
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			first_level_out  <= LEVEL_RESET;
			second_level_out <= LEVEL_RESET;
			first_high_out   <= SCALE_RESET;
			second_high_out  <= SCALE_RESET;
			sinks_on_out     <= 1'b0;
			standby_out      <= 1'b0;
			voltage_mode_out <= 1'b0;
			pump_en_out      <= 1'b0;
			soft_start_out   <= 1'b0;
			pump_ratio_out   <= RATIO_1X;
			shutdown_out     <= 1'b1;
			addr_out         <= ADDR_BOTH;
		end else begin
			first_level_out  <= lvl1_q;
			second_level_out <= lvl2_q;
			first_high_out   <= hi1_q;
			second_high_out  <= hi2_q;
			sinks_on_out     <= !shut_q && onoff_q == ONOFF_ON
				&& !volt_q;
			standby_out      <= !shut_q && onoff_q == ONOFF_OFF
				&& !volt_q;
			voltage_mode_out <= volt_q;
			pump_en_out      <= st_q != ST_OFF && !standby_out;
			soft_start_out   <= st_q == ST_SOFT && !soft_done;
			pump_ratio_out   <= ratio_q;
			shutdown_out     <= shut_q;
			addr_out         <= addr_q;
		end
	end
endmodule

//--- verif/led_sink_ctrl_props.sv
// checker for led_sink_ctrl, watching its ports only
// assumes a 40 MHz clock and tick counts handed on by the bind
`timescale 1ns/100ps
module led_sink_ctrl_props
	import led_sink_pkg::*;
#(
	parameter int unsigned LATCH_CYC = LATCH_TICKS,
	parameter int unsigned SOFT_CYC  = SOFT_TICKS
) (
	input wire logic       ref_clk_in,       // clock
	input wire logic       rst_in,           // reset
	input wire logic       ctrl_pin_in,      // control pin
	input wire logic [3:0] first_level_out,  // first sink code
	input wire logic [3:0] second_level_out, // second sink code
	input wire logic       first_high_out,   // first high scale
	input wire logic       sinks_on_out,     // sinks enabled
	input wire logic       standby_out,      // standby
	input wire logic       voltage_mode_out, // voltage mode
	input wire logic       pump_en_out,      // pump running
	input wire logic       soft_start_out,   // soft start
	input wire logic [1:0] pump_ratio_out,   // pump ratio
	input wire logic       shutdown_out,     // shutdown
	input wire logic [2:0] addr_out          // selected address
);
	// ****************************************
	// run-length helpers and assertions
	// ****************************************
	// one tick of slack: the tick phase is unknown at the pin edge
	localparam int unsigned LATCH_MIN = (LATCH_CYC - 1) * OSC_DIV;
	localparam int unsigned SOFT_MIN  = (SOFT_CYC - 1) * OSC_DIV;
	localparam int unsigned SOFT_MAX  = (SOFT_CYC + 1) * OSC_DIV;
	logic [15:0] hi_cnt_q;
	logic [15:0] soft_cnt_q;
	logic        sink_busy;
	assign sink_busy = sinks_on_out && (first_level_out != LEVEL_ZERO ||
		second_level_out != LEVEL_ZERO);
	// saturates so a long idle high never wraps
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			hi_cnt_q <= 16'h0000;
		else if (!ctrl_pin_in)
			hi_cnt_q <= 16'h0000;
		else if (hi_cnt_q != 16'hffff)
			hi_cnt_q <= hi_cnt_q + 16'h0001;
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			soft_cnt_q <= 16'h0000;
		else if (!soft_start_out)
			soft_cnt_q <= 16'h0000;
		else
			soft_cnt_q <= soft_cnt_q + 16'h0001;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_LEVEL_LATCH: assert property (
		$changed(first_level_out) && ctrl_pin_in |-> hi_cnt_q >= LATCH_MIN)
		else $error("sink level changed before latch timeout");
	AST_ADDR_LATCH: assert property (
		$changed(addr_out) && ctrl_pin_in |-> hi_cnt_q >= LATCH_MIN)
		else $error("address changed without a latched burst");
	AST_SHDN_CLEAR: assert property ($rose(shutdown_out) |-> ##[0:3]
		(first_level_out == LEVEL_ZERO && second_level_out == LEVEL_ZERO &&
		addr_out == ADDR_BOTH && first_high_out == SCALE_RESET))
		else $error("shutdown did not restore defaults");
	AST_SHDN_OFF: assert property (
		shutdown_out ##1 shutdown_out |-> !pump_en_out && !sinks_on_out)
		else $error("pump or sinks active in shutdown");
	AST_STANDBY: assert property (standby_out |-> !sinks_on_out)
		else $error("sinks on during standby");
	AST_VOLT_OVR: assert property (sink_busy[*3] |-> !voltage_mode_out)
		else $error("voltage mode with a sink drawing current");
	AST_VOLT_RATIO: assert property (
		$rose(voltage_mode_out) |-> ##[0:80] pump_ratio_out == RATIO_15X)
		else $error("voltage mode without 1.5x ratio");
	AST_SOFT_START: assert property (
		$fell(shutdown_out) |-> ##[0:4] soft_start_out[*8])
		else $error("no soft start on wake");
	AST_SOFT_LEN: assert property (soft_cnt_q <= SOFT_MAX and
		($fell(soft_start_out) |-> soft_cnt_q >= SOFT_MIN))
		else $error("soft start length off");
	cover property ($rose(voltage_mode_out));
	cover property ($rose(standby_out));
	cover property ($rose(shutdown_out));
endmodule

bind led_sink_ctrl led_sink_ctrl_props #(
	.LATCH_CYC(LATCH_CYC),
	.SOFT_CYC (SOFT_CYC)
) props_i (
	.ref_clk_in, .rst_in, .ctrl_pin_in, .first_level_out,
	.second_level_out, .first_high_out, .sinks_on_out, .standby_out,
	.voltage_mode_out, .pump_en_out, .soft_start_out, .pump_ratio_out,
	.shutdown_out, .addr_out
);

//--- verif/host_gpio.sv
// host gpio model toggling the single control pin
// assumes callers run one task at a time, entered just after an edge
`timescale 1ns/100ps
module host_gpio
	import led_sink_pkg::*;
#(
	parameter int unsigned LATCH_CYC = 5,
	parameter int unsigned OFF_CYC   = 5
) (
	input  wire logic ref_clk_in, // system clock
	output logic      pin_out     // control pin level
);
	// ****************************************
	// pin drive tasks
	// ****************************************
	initial pin_out = 1'b0;
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_in);
		#2;
	endtask
	// low 300 ns keeps above the minimum low time
	task automatic send(input int edges);
		for (int i = 0; i < edges; i++) begin
			pin_out = 1'b0;
			wait_clk(12);
			pin_out = 1'b1;
			wait_clk(4);
		end
		wait_clk((LATCH_CYC + 2) * OSC_DIV);
	endtask
	task automatic park_low();
		pin_out = 1'b0;
		wait_clk((OFF_CYC + 3) * OSC_DIV);
	endtask
endmodule

//--- verif/test_led_sink_ctrl.sv
// self-checking bench for led_sink_ctrl driven through its pin
// assumes host_gpio drives the pin and the checker is bound in
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
	failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_led_sink_ctrl;
	import led_sink_pkg::*;
	// ****************************************
	// bench
	// ****************************************
	localparam int unsigned CYC = 5;
	logic       ref_clk_in;
	logic       rst_in;
	logic       ctrl_pin;
	logic       pump_low;
	logic       pump_high;
	logic [3:0] first_level;
	logic [3:0] second_level;
	logic       first_high;
	logic       second_high;
	logic       sinks_on;
	logic       standby;
	logic       volt_mode;
	logic       pump_en;
	logic       soft_start;
	logic [1:0] ratio;
	logic       shutdown;
	logic [2:0] addr;
	int         failures;
	int         checks;
	int         cycles;
	logic [1:0] exp_hi [1:4] = '{2'b00, 2'b11, 2'b01, 2'b10};
	led_sink_ctrl #(.LATCH_CYC(CYC), .OFF_CYC(CYC), .SOFT_CYC(CYC)) dut (
		.ref_clk_in, .rst_in, .ctrl_pin_in(ctrl_pin),
		.pump_low_in(pump_low), .pump_high_in(pump_high),
		.first_level_out(first_level), .second_level_out(second_level),
		.first_high_out(first_high), .second_high_out(second_high),
		.sinks_on_out(sinks_on), .standby_out(standby),
		.voltage_mode_out(volt_mode), .pump_en_out(pump_en),
		.soft_start_out(soft_start), .pump_ratio_out(ratio),
		.shutdown_out(shutdown), .addr_out(addr));
	// host timing defaults equal CYC
	host_gpio host (
		.ref_clk_in, .pin_out(ctrl_pin));
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [4:0] d);
		host.send(17 + int'(a));
		host.send(int'(d));
	endtask
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		rst_in = 1'b1;
		pump_low = 1'b0;
		pump_high = 1'b0;
		failures = 0;
		checks = 0;
		cycles = 0;
		repeat (3) @(posedge ref_clk_in);
		#2 rst_in = 1'b0;
		`CHK("shutdown", 1'b1, shutdown)
		host.send(5);
		`CHK("first", 4'h5, first_level)
		`CHK("second", 4'h5, second_level)
		`CHK("sinks_on", 1'b1, sinks_on)
		`CHK("pump_en", 1'b1, pump_en)
		`CHK("soft", 1'b0, soft_start)
		wr(ADDR_FIRST, 5'h10);
		`CHK("first", LEVEL_ZERO, first_level)
		`CHK("second", 4'h5, second_level)
		`CHK("addr", ADDR_FIRST, addr)
		host.send(7);
		`CHK("first", 4'h7, first_level)
		wr(ADDR_SECND, 5'h03);
		`CHK("second", 4'h3, second_level)
		`CHK("first", 4'h7, first_level)
		for (int d = 1; d <= 4; d++) begin
			wr(ADDR_SCALE, 5'(d));
			`CHK("scale", exp_hi[d], {first_high, second_high})
		end
		wr(ADDR_ONOFF, {1'b0, ONOFF_OFF});
		`CHK("standby", 1'b1, standby)
		host.send(1);
		`CHK("sinks_on", 1'b1, sinks_on)
		pump_low = 1'b1;
		host.wait_clk(200);
		`CHK("ratio", RATIO_2X, ratio)
		pump_low = 1'b0;
		pump_high = 1'b1;
		host.wait_clk(200);
		`CHK("ratio", RATIO_1X, ratio)
		pump_high = 1'b0;
		wr(ADDR_MODE, {1'b0, MODE_VOLT});
		`CHK("volt", 1'b0, volt_mode)
		wr(ADDR_BOTH, 5'h10);
		`CHK("volt", 1'b1, volt_mode)
		`CHK("ratio", RATIO_15X, ratio)
		wr(ADDR_FIRST, 5'h04);
		`CHK("volt", 1'b0, volt_mode)
		host.send(16);
		`CHK("volt", 1'b1, volt_mode)
		wr(ADDR_RSVD, 5'h01);
		`CHK("volt", 1'b0, volt_mode)
		host.park_low();
		`CHK("shutdown", 1'b1, shutdown)
		`CHK("addr", ADDR_BOTH, addr)
		`CHK("scale", {SCALE_RESET, SCALE_RESET}, {first_high, second_high})
		host.send(9);
		`CHK("first", 4'h9, first_level)
		`CHK("second", 4'h9, second_level)
		close_out();
	end
endmodule
